/* File: verilog/rcb_pkg.sv */
// rcb_pkg: constants, register map and carrier types of the
// read/capacity/buffer-readback command block.
// assumes a 40 MHz controller clock and a classic wishbone host.
package rcb_pkg;

	// operation codes
	localparam logic [7:0] OP_READ6    = 8'h08;
	localparam logic [7:0] OP_READ10   = 8'h28;
	localparam logic [7:0] OP_CAPACITY = 8'h25;
	localparam logic [7:0] OP_BUF_READ = 8'h3C;

	// sense keys
	localparam logic [3:0] SK_NONE       = 4'h0;
	localparam logic [3:0] SK_ILLEGAL    = 4'h5;
	localparam logic [3:0] SK_MISCOMPARE = 4'hE;

	// descriptor and answer sizes
	localparam logic [3:0]  CDB_LEN6    = 4'h6;
	localparam logic [3:0]  CDB_LEN10   = 4'hA;
	localparam logic [16:0] CAP_BYTES   = 17'h0_0008;
	localparam logic [16:0] HDR_BYTES   = 17'h0_0004;
	localparam logic [16:0] READ6_ZERO  = 17'h0_0100;
	localparam logic [16:0] AVAIL_LIMIT = 17'h0_FFFF;

	// register byte offsets
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_LAST_LBA = 8'h04;
	localparam logic [7:0] REG_BLK_LEN  = 8'h08;
	localparam logic [7:0] REG_TRK_MASK = 8'h0C;
	localparam logic [7:0] REG_BUF_PTR  = 8'h10;
	localparam logic [7:0] REG_BUF_DATA = 8'h14;
	localparam logic [7:0] REG_BUF_LEN  = 8'h18;
	localparam logic [7:0] REG_STATUS   = 8'h1C;
	localparam logic [7:0] REG_MASK     = 8'h20;
	localparam logic [7:0] REG_STATE    = 8'h24;

	// reset values
	localparam logic [31:0] CTRL_RST     = 32'h0000_0001;
	localparam logic [31:0] LAST_LBA_RST = 32'h0000_0000;
	localparam logic [31:0] BLK_LEN_RST  = 32'h0000_0100;
	localparam logic [31:0] TRK_MASK_RST = 32'h0000_003F;

	// field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int ST_DONE     = 0;
	localparam int ST_CHECK    = 1;
	localparam int ST_MISCMP   = 2;
	localparam int ST_W        = 3;

	typedef enum logic [2:0] {
		S_IDLE   = 3'b000,
		S_CDB    = 3'b001,
		S_DECODE = 3'b010,
		S_SEND   = 3'b011,
		S_MEDIA  = 3'b100,
		S_DONE   = 3'b101
	} rcb_state_e;

	typedef struct packed {
		logic       valid;
		logic       last;
		logic [7:0] data;
	} rcb_din_s;

	typedef struct packed {
		logic        req;
		logic [31:0] lba;
		logic [16:0] count;
	} rcb_media_s;

	typedef struct packed {
		logic       done;
		logic       check;
		logic [3:0] sense;
	} rcb_resp_s;

endpackage

/* File: verilog/rcb_buf_mem.sv */
// rcb_buf_mem: byte-wide data buffer, one write port, one read port.
// assumes the write side comes from the register bus.
`timescale 1ns/1ps
`default_nettype none
module rcb_buf_mem #(
	parameter int DEPTH = 256,
	parameter int AW    = 8
) (
	// clock
	input  wire logic          clk_i,
	// write port
	input  wire logic          we_i,
	input  wire logic [AW-1:0] waddr_i,
	input  wire logic [7:0]    wdata_i,
	// read port, combinational
	input  wire logic [AW-1:0] raddr_i,
	output logic      [7:0]    rdata_o
);
	logic [7:0] mem_q [DEPTH];

	// no reset: contents are undefined until written
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem_q[waddr_i] <= wdata_i;
		end
	end

	assign rdata_o = mem_q[raddr_i];
endmodule
`default_nettype wire

/* File: verilog/rcb_cmd.sv */
// rcb_cmd: target-side decode and execution of block read, capacity
// query and buffer readback descriptors, with a wishbone register file.
// assumes phase sequencing outside feeds descriptor bytes and drains
// the data-in stream; media access answers on media_done_i.
// Functional notes
// - both 6-byte and 10-byte read descriptors are accepted and executed
// - 10-byte read with count zero moves nothing, no error, acts as seek
// - read starts at the addressed block, returning latest written data
// - capacity query opcode 25h answers with unit capacity
// - partial flag clear: report last block address and block length
// - partial flag set: last block before a delay, at or above request
// - capacity answer is eight bytes: address then length, msb first
// - buffer readback opcode 3ch returns internal buffer contents
// - buffer readback with allocation zero moves nothing, no error
// - readback ends after the lesser of allocation or available data
// - four-byte header first: two reserved, then 16-bit available length
// - available length capped at 65535 and at real buffer size
// - available length zero means no buffer bytes after header
// - truncation never alters the reported available length
// - other command between buffer write and readback: miscompare check
// - miscompare still transfers the requested data
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rcb_cmd #(
	parameter int DEPTH = 256,
	parameter int AW    = 8
) (
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// wishbone slave
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               wb_we_i,
	input  wire logic [7:0]         wb_adr_i,
	input  wire logic [3:0]         wb_sel_i,
	input  wire logic [31:0]        wb_dat_i,
	output logic      [31:0]        wb_dat_o,
	output logic                    wb_ack_o,
	// descriptor bytes in
	input  wire logic               cdb_valid_i,
	input  wire logic [7:0]         cdb_byte_i,
	// data-in stream
	output rcb_pkg::rcb_din_s       din_o,
	input  wire logic               din_ready_i,
	// media read request
	output rcb_pkg::rcb_media_s     media_o,
	input  wire logic               media_done_i,
	// completion and interrupt
	output rcb_pkg::rcb_resp_s      resp_o,
	output logic                    irq_o
);
	import rcb_pkg::*;

	rcb_state_e       st_q;
	logic [7:0]       cdb_q [10];
	logic [3:0]       cnt_q;
	logic [31:0]      ctrl_q, last_lba_q, blk_len_q, trk_mask_q;
	logic [AW-1:0]    ptr_q;
	logic [15:0]      buf_len_q, avail_cmd_q;
	logic [ST_W-1:0]  status_q, status_d, mask_q, set_ev;
	logic             ack_q, stale_q, miscmp_q, err_q, buf_mode_q;
	logic [31:0]      rdat_q;
	logic [63:0]      cap_word_q;
	logic [16:0]      total_q, idx_q;
	rcb_din_s         din_q;
	rcb_media_s       media_q;
	rcb_resp_s        resp_q;
	logic [7:0]       mem_rd, byte_sel;
	logic             wr_en, rd_en;
	logic [7:0]       opc;
	logic [31:0]      lba10, lba6, pmi_lba;
	logic [16:0]      cnt10, cnt6, alloc, avail_all, buf_total;
	logic [15:0]      avail_rep;
	logic             relative_addressing_bit, partial_medium_flag, cap_bad;
	logic [16:0]      rd_ofs;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	// descriptor fields
	assign opc       = cdb_q[0];
	assign relative_addressing_bit       = cdb_q[1][0];
	assign partial_medium_flag       = cdb_q[8][0];
	assign lba10     = {cdb_q[2], cdb_q[3], cdb_q[4], cdb_q[5]};
	assign cnt10     = {1'b0, cdb_q[7], cdb_q[8]};
	assign lba6      = {11'h000, cdb_q[1][4:0], cdb_q[2], cdb_q[3]};
	assign cnt6      = (cdb_q[4] == 8'h00) ? READ6_ZERO
		: {9'h000, cdb_q[4]};
	assign alloc     = {1'b0, cdb_q[7], cdb_q[8]};
	// track end, clamped to unit end
	assign pmi_lba   = ((lba10 | trk_mask_q) > last_lba_q) ? last_lba_q
		: (lba10 | trk_mask_q);
	assign cap_bad   = relative_addressing_bit || (!partial_medium_flag && lba10 != 32'h0000_0000)
		|| (partial_medium_flag && lba10 > last_lba_q);
	// available length never above buffer size or 16 bits
	assign avail_rep = (buf_len_q > 16'(DEPTH)) ? 16'(DEPTH)
		: buf_len_q;
	assign avail_all = HDR_BYTES + {1'b0, avail_rep};
	assign buf_total = (alloc < avail_all) ? alloc : avail_all;

	// wishbone: answer one cycle after the strobe, unmapped reads zero
	assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
	assign rd_en = wb_cyc_i && wb_stb_i && !ack_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_q <= 32'h0000_0000;
		end else if (rd_en) begin
			unique case (wb_adr_i)
			REG_CTRL:     rdat_q <= ctrl_q;
			REG_LAST_LBA: rdat_q <= last_lba_q;
			REG_BLK_LEN:  rdat_q <= blk_len_q;
			REG_TRK_MASK: rdat_q <= trk_mask_q;
			REG_BUF_PTR:  rdat_q <= 32'(ptr_q);
			REG_BUF_LEN:  rdat_q <= {16'h0000, buf_len_q};
			REG_STATUS:   rdat_q <= 32'(status_q);
			REG_MASK:     rdat_q <= 32'(mask_q);
			REG_STATE:    rdat_q <= {20'h0_0000, resp_q.sense,
				stale_q, 4'h0, st_q};
			default:      rdat_q <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q     <= CTRL_RST;
			last_lba_q <= LAST_LBA_RST;
			blk_len_q  <= BLK_LEN_RST;
			trk_mask_q <= TRK_MASK_RST;
			mask_q     <= '0;
		end else if (wr_en) begin
			unique case (wb_adr_i)
			REG_CTRL:     ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i);
			REG_LAST_LBA: last_lba_q <= merge(last_lba_q, wb_dat_i,
				wb_sel_i);
			REG_BLK_LEN:  blk_len_q <= merge(blk_len_q, wb_dat_i,
				wb_sel_i);
			REG_TRK_MASK: trk_mask_q <= merge(trk_mask_q, wb_dat_i,
				wb_sel_i);
			REG_MASK:     mask_q <= wb_dat_i[ST_W-1:0];
			default:      ;
			endcase
		end
	end

	// buffer fill: byte writes auto-increment the pointer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ptr_q     <= '0;
			buf_len_q <= 16'h0000;
		end else if (wr_en && wb_adr_i == REG_BUF_PTR) begin
			ptr_q <= wb_dat_i[AW-1:0];
		end else if (wr_en && wb_adr_i == REG_BUF_DATA && wb_sel_i[0]) begin
			ptr_q <= ptr_q + 1'b1;
		end else if (wr_en && wb_adr_i == REG_BUF_LEN) begin
			buf_len_q <= wb_dat_i[15:0];
		end
	end

	// writing the length closes a buffer write; any other command
	// decoded afterwards marks the contents suspect
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stale_q <= 1'b0;
		end else if (st_q == S_DECODE && opc != OP_BUF_READ) begin
			stale_q <= 1'b1;
		end else if (wr_en && wb_adr_i == REG_BUF_LEN) begin
			stale_q <= 1'b0;
		end
	end

	assign rd_ofs = idx_q - HDR_BYTES;

	rcb_buf_mem #(
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_mem (
		.clk_i   (clk_i),
		.we_i    (wr_en && wb_adr_i == REG_BUF_DATA && wb_sel_i[0]),
		.waddr_i (ptr_q),
		.wdata_i (wb_dat_i[7:0]),
		.raddr_i (rd_ofs[AW-1:0]),
		.rdata_o (mem_rd)
	);

	// byte for the current stream position
	always_comb begin
		byte_sel = 8'h00;
		if (!buf_mode_q) begin
			byte_sel = cap_word_q[8*(7 - idx_q[2:0]) +: 8];
		end else if (idx_q == 17'h0_0002) begin
			byte_sel = avail_cmd_q[15:8];
		end else if (idx_q == 17'h0_0003) begin
			byte_sel = avail_cmd_q[7:0];
		end else if (idx_q >= HDR_BYTES) begin
			byte_sel = mem_rd;
		end
	end

	// command sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q        <= S_IDLE;
			cnt_q       <= 4'h0;
			err_q       <= 1'b0;
			miscmp_q    <= 1'b0;
			buf_mode_q  <= 1'b0;
			cap_word_q  <= '0;
			total_q     <= '0;
			idx_q       <= '0;
			avail_cmd_q <= 16'h0000;
			din_q       <= '0;
			media_q     <= '0;
			for (int i = 0; i < 10; i++) begin
				cdb_q[i] <= 8'h00;
			end
		end else begin
			unique case (st_q)
			S_IDLE: begin
				err_q    <= 1'b0;
				miscmp_q <= 1'b0;
				idx_q    <= '0;
				if (ctrl_q[CTRL_EN_BIT] && cdb_valid_i) begin
					cdb_q[0] <= cdb_byte_i;
					cnt_q    <= 4'h1;
					st_q     <= S_CDB;
				end
			end
			S_CDB: begin
				if (cdb_valid_i) begin
					cdb_q[cnt_q] <= cdb_byte_i;
					cnt_q        <= cnt_q + 1'b1;
					// group-zero codes are six bytes long
					if (cnt_q == ((opc[7:5] == 3'b000) ? CDB_LEN6
						: CDB_LEN10) - 4'h1) begin
						st_q <= S_DECODE;
					end
				end
			end
			S_DECODE: begin
				buf_mode_q <= (opc == OP_BUF_READ);
				unique case (opc)
				OP_READ6: begin
					media_q <= '{req: 1'b1, lba: lba6, count: cnt6};
					st_q    <= S_MEDIA;
				end
				OP_READ10: begin
					if (relative_addressing_bit) begin
						err_q <= 1'b1;
						st_q  <= S_DONE;
					end else if (cnt10 == 17'h0_0000) begin
						st_q <= S_DONE;
					end else begin
						media_q <= '{req: 1'b1, lba: lba10,
							count: cnt10};
						st_q    <= S_MEDIA;
					end
				end
				OP_CAPACITY: begin
					if (cap_bad) begin
						err_q <= 1'b1;
						st_q  <= S_DONE;
					end else begin
						cap_word_q <= {partial_medium_flag ? pmi_lba : last_lba_q,
							blk_len_q};
						total_q    <= CAP_BYTES;
						st_q       <= S_SEND;
					end
				end
				OP_BUF_READ: begin
					miscmp_q    <= stale_q;
					avail_cmd_q <= avail_rep;
					total_q     <= buf_total;
					if (relative_addressing_bit) begin
						err_q <= 1'b1;
						st_q  <= S_DONE;
					end else if (buf_total == 17'h0_0000) begin
						st_q <= S_DONE;
					end else begin
						st_q <= S_SEND;
					end
				end
				default: begin
					err_q <= 1'b1;
					st_q  <= S_DONE;
				end
				endcase
			end
			S_SEND: begin
				if (!din_q.valid || din_ready_i) begin
					if (idx_q < total_q) begin
						din_q <= '{valid: 1'b1,
							last: idx_q == total_q - 17'h0_0001,
							data: byte_sel};
						idx_q <= idx_q + 17'h0_0001;
					end else begin
						din_q.valid <= 1'b0;
						din_q.last  <= 1'b0;
						st_q        <= S_DONE;
					end
				end
			end
			S_MEDIA: begin
				// held until the media side finishes the blocks
				if (media_done_i) begin
					media_q.req <= 1'b0;
					st_q        <= S_DONE;
				end
			end
			S_DONE: st_q <= S_IDLE;
			default: st_q <= S_IDLE;
			endcase
		end
	end

	// completion: illegal request beats miscompare
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			resp_q <= '0;
		end else if (st_q == S_DONE) begin
			resp_q.done  <= 1'b1;
			resp_q.check <= err_q || (buf_mode_q && miscmp_q);
			resp_q.sense <= err_q ? SK_ILLEGAL
				: (buf_mode_q && miscmp_q) ? SK_MISCOMPARE
				: SK_NONE;
		end else begin
			resp_q.done <= 1'b0;
		end
	end

	// sticky events, write one to clear, set wins
	always_comb begin
		set_ev = '0;
		set_ev[ST_DONE]   = (st_q == S_DONE);
		set_ev[ST_CHECK]  = (st_q == S_DONE) && err_q;
		set_ev[ST_MISCMP] = (st_q == S_DONE) && buf_mode_q && miscmp_q;
		status_d = status_q;
		if (wr_en && wb_adr_i == REG_STATUS) begin
			status_d = status_q & ~wb_dat_i[ST_W-1:0];
		end
		status_d = status_d | set_ev;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_q <= '0;
			irq_o    <= 1'b0;
		end else begin
			status_q <= status_d;
			irq_o    <= |(status_d & mask_q);
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign din_o    = din_q;
	assign media_o  = media_q;
	assign resp_o   = resp_q;

	read10_seek_a: assert property (@(posedge clk_i) disable iff (rst_i)
		st_q == S_DECODE && opc == OP_READ10 && !relative_addressing_bit && cnt10 == 17'h0
		|=> st_q == S_DONE && !media_q.req ##1 !resp_q.check)
		else $error("zero-length read did not complete as seek");

	read10_rel_a: assert property (@(posedge clk_i) disable iff (rst_i)
		st_q == S_DECODE && opc == OP_READ10 && relative_addressing_bit
		|=> ##1 resp_q.done && resp_q.sense == SK_ILLEGAL)
		else $error("relative read not refused");

	read6_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
		st_q == S_DECODE && opc == OP_READ6
		|=> media_q.req && media_q.count == $past(cnt6)
			&& media_q.lba == $past(lba6))
		else $error("short read request wrong");

	read_lba_a: assert property (@(posedge clk_i) disable iff (rst_i)
		st_q == S_DECODE && opc == OP_READ10 && !relative_addressing_bit && cnt10 != 17'h0
		|=> media_q.req && media_q.lba == $past(lba10)
			&& media_q.count == $past(cnt10))
		else $error("read request address or count wrong");

	cap_full_a: assert property (@(posedge clk_i) disable iff (rst_i)
		st_q == S_DECODE && opc == OP_CAPACITY && !cap_bad && !partial_medium_flag
		|=> cap_word_q == {$past(last_lba_q), $past(blk_len_q)}
			&& total_q == 17'h0_0008)
		else $error("capacity answer wrong");

	cap_pmi_a: assert property (@(posedge clk_i) disable iff (rst_i)
		st_q == S_DECODE && opc == OP_CAPACITY && !cap_bad && partial_medium_flag
		|=> cap_word_q[63:32] >= $past(lba10)
			&& cap_word_q[63:32] <= $past(last_lba_q))
		else $error("partial capacity address out of range");

	buf_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		st_q == S_DECODE && opc == OP_BUF_READ && !relative_addressing_bit && alloc == 17'h0
		|=> st_q == S_DONE ##1 resp_q.done && resp_q.sense != SK_ILLEGAL)
		else $error("zero allocation readback misbehaved");

	buf_trunc_a: assert property (@(posedge clk_i) disable iff (rst_i)
		st_q == S_DECODE && opc == OP_BUF_READ
		|=> total_q <= $past(alloc) && total_q <= $past(avail_all)
			&& (total_q == $past(alloc) || total_q == $past(avail_all)))
		else $error("readback length not the lesser amount");

	hdr_empty_a: assert property (@(posedge clk_i) disable iff (rst_i)
		din_q.valid && buf_mode_q && idx_q > HDR_BYTES
		|-> avail_cmd_q != 16'h0000)
		else $error("buffer bytes sent with zero available length");

	avail_cap_a: assert property (@(posedge clk_i) disable iff (rst_i)
		avail_cmd_q <= 16'(DEPTH))
		else $error("available length above buffer size");

	miscmp_resp_a: assert property (@(posedge clk_i) disable iff (rst_i)
		st_q == S_DONE && buf_mode_q && miscmp_q && !err_q
		|=> resp_q.check && resp_q.sense == SK_MISCOMPARE)
		else $error("miscompare not reported");

	stale_mark_a: assert property (@(posedge clk_i) disable iff (rst_i)
		st_q == S_DECODE && opc != OP_BUF_READ |=> stale_q)
		else $error("other command did not mark buffer suspect");
endmodule
`default_nettype wire

/* File: verif/rcb_host_model.sv */
// rcb_host_model: initiator-side sink for the data-in stream, media stub.
// assumes one clock with the design; the bench reads rx and counts.
`timescale 1ns/1ps
`default_nettype none
module rcb_host_model (
	// clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	input  wire logic                clr_i,
	// data-in stream
	input  wire rcb_pkg::rcb_din_s   din_i,
	output logic                     ready_o,
	// media
	input  wire rcb_pkg::rcb_media_s media_i,
	output logic                     done_o
);
	import rcb_pkg::*;
	logic [7:0]  rx [0:31];
	int          n_rx;
	int          last_at;
	int          n_req;
	logic [31:0] m_lba;
	logic [16:0] m_cnt;
	logic [1:0]  w_q;
	// stalls every other cycle so valid must be held
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ready_o <= 1'b0;
		end else begin
			ready_o <= ~ready_o;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || clr_i) begin
			n_rx    <= 0;
			last_at <= -1;
		end else if (din_i.valid && ready_o && n_rx < 32) begin
			rx[n_rx] <= din_i.data;
			n_rx     <= n_rx + 1;
			if (din_i.last) begin
				last_at <= n_rx;
			end
		end
	end
	// media answers late, three cycles after req
	always_ff @(posedge clk_i) begin
		if (rst_i || clr_i) begin
			done_o <= 1'b0;
			w_q    <= 2'h0;
			n_req  <= 0;
		end else if (media_i.req && !done_o) begin
			w_q   <= w_q + 2'h1;
			m_lba <= media_i.lba;
			m_cnt <= media_i.count;
			if (w_q == 2'h2) begin
				done_o <= 1'b1;
				n_req  <= n_req + 1;
			end
		end else begin
			done_o <= 1'b0;
			w_q    <= 2'h0;
		end
	end
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// tb: self-checking bench for rcb_cmd.
// assumes rcb_host_model as far side, wishbone master in the bench.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import rcb_pkg::*;
	logic        clk_i, rst_i, cyc, stb, we, cv, clr, rdy, mdone, ack, irq;
	logic [7:0]  adr, cb;
	logic [31:0] dat, wdo, rd;
	rcb_din_s    din;
	rcb_media_s  med;
	rcb_resp_s   rsp;
	int          err_count, n_tests;
	rcb_cmd i_rcb_cmd (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(dat), .wb_dat_o(wdo), .wb_ack_o(ack), .cdb_valid_i(cv),
		.cdb_byte_i(cb), .din_o(din), .din_ready_i(rdy), .media_o(med),
		.media_done_i(mdone), .resp_o(rsp), .irq_o(irq));
	rcb_host_model i_rcb_host_model (.clk_i(clk_i), .rst_i(rst_i),
		.clr_i(clr), .din_i(din), .ready_o(rdy), .media_i(med),
		.done_o(mdone));
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	// whole run is far below this span
	initial begin
		#(25 * 30000);
		err_count++;
		$display("mismatch %0t watchdog", $time);
		stop_test();
	end
	task automatic stop_test();
		if (err_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, e, input string m);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 50);
		rd = wdo;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (k >= 50)
			chk(0, 1, "no ack");
	endtask
	task automatic cmd(input logic [79:0] c, input int n, input logic ck,
		input logic [3:0] sk);
		int k;
		@(posedge clk_i);
		clr <= 1'b1;
		for (k = 0; k < n; k++) begin
			@(posedge clk_i);
			clr <= 1'b0;
			cv  <= 1'b1;
			cb  <= c[79-8*k -: 8];
		end
		@(posedge clk_i);
		cv <= 1'b0;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (rsp.done !== 1'b1 && k < 2000);
		if (k >= 2000)
			chk(0, 1, "no done");
		chk(rsp.check, ck, "check");
		chk(rsp.sense, sk, "sense");
	endtask
	task automatic rx_chk(input logic [63:0] e, input int n);
		int k;
		chk(i_rcb_host_model.n_rx, n, "byte count");
		for (k = 0; k < n; k++)
			chk(i_rcb_host_model.rx[k], e[63-8*k -: 8], "byte");
		if (n > 0)
			chk(i_rcb_host_model.last_at, n - 1, "last");
	endtask
	task automatic bufset(input logic [31:0] len);
		int k;
		wb(1'b1, REG_BUF_PTR, 32'h0000_0000);
		for (k = 0; k < 8; k++)
			wb(1'b1, REG_BUF_DATA, 32'h0000_00A0 + k);
		wb(1'b1, REG_BUF_LEN, len);
	endtask
	task automatic t_reset();
		wb(1'b0, REG_CTRL, 32'h0000_0000);
		chk(rd, CTRL_RST, "ctrl");
		wb(1'b0, REG_BLK_LEN, 32'h0000_0000);
		chk(rd, BLK_LEN_RST, "blk len");
		wb(1'b0, REG_TRK_MASK, 32'h0000_0000);
		chk(rd, TRK_MASK_RST, "trk mask");
		wb(1'b1, 8'hFC, 32'hFFFF_FFFF);
		wb(1'b0, 8'hFC, 32'h0000_0000);
		chk(rd, 32'h0000_0000, "unmapped");
		chk(irq, 1'b0, "irq idle");
	endtask
	task automatic t_cap();
		wb(1'b1, REG_LAST_LBA, 32'h0000_1234);
		wb(1'b1, REG_BLK_LEN, 32'h0000_0200);
		cmd({8'h25, 72'h0}, 10, 1'b0, SK_NONE);
		rx_chk(64'h0000_1234_0000_0200, 8);
		cmd({16'h2500, 32'h0000_0101, 16'h0, 16'h0100}, 10, 1'b0,
			SK_NONE);
		rx_chk(64'h0000_013F_0000_0200, 8);
		cmd({16'h2500, 32'h0000_0005, 32'h0}, 10, 1'b1, SK_ILLEGAL);
	endtask
	task automatic t_read();
		cmd({16'h2800, 32'h0102_0304, 8'h00, 16'h0002, 8'h00}, 10,
			1'b0, SK_NONE);
		chk(i_rcb_host_model.m_lba, 32'h0102_0304, "lba");
		chk(i_rcb_host_model.m_cnt, 32'h0000_0002, "cnt");
		cmd({16'h2800, 32'h0102_0304, 32'h0}, 10, 1'b0, SK_NONE);
		chk(i_rcb_host_model.n_req, 0, "seek");
		cmd({16'h2801, 48'h0, 16'h0100}, 10, 1'b1, SK_ILLEGAL);
		chk(i_rcb_host_model.n_req, 0, "rel");
		cmd({48'h0801_0203_0000, 32'h0}, 6, 1'b0, SK_NONE);
		chk(i_rcb_host_model.m_lba, 32'h0001_0203, "lba6");
		chk(i_rcb_host_model.m_cnt, 32'h0000_0100, "cnt6");
	endtask
	task automatic t_buf();
		bufset(32'h0000_0008);
		cmd({8'h3C, 48'h0, 16'h0006, 8'h0}, 10, 1'b0, SK_NONE);
		rx_chk(64'h0000_0008_A0A1_0000, 6);
		bufset(32'h0000_0008);
		cmd({8'h3C, 72'h0}, 10, 1'b0, SK_NONE);
		rx_chk(64'h0, 0);
		bufset(32'h0000_0000);
		cmd({8'h3C, 48'h0, 16'h000A, 8'h0}, 10, 1'b0, SK_NONE);
		rx_chk(64'h0, 4);
		bufset(32'h0000_012C);
		cmd({8'h3C, 48'h0, 16'h0004, 8'h0}, 10, 1'b0, SK_NONE);
		rx_chk(64'h0000_0100_0000_0000, 4);
	endtask
	task automatic t_miscmp();
		wb(1'b1, REG_MASK, 32'h0000_0004);
		chk(irq, 1'b0, "irq masked");
		bufset(32'h0000_0008);
		cmd({8'h25, 72'h0}, 10, 1'b0, SK_NONE);
		cmd({8'h3C, 48'h0, 16'h0005, 8'h0}, 10, 1'b1,
			SK_MISCOMPARE);
		rx_chk(64'h0000_0008_A000_0000, 5);
		chk(irq, 1'b1, "irq set");
		wb(1'b0, REG_STATUS, 32'h0000_0000);
		chk(rd[ST_MISCMP], 1'b1, "status");
		wb(1'b1, REG_STATUS, 32'h0000_0007);
		repeat (3) @(posedge clk_i);
		chk(irq, 1'b0, "irq clear");
	endtask
	initial begin
		rst_i = 1'b1;
		{cyc, stb, we, cv, clr} = 5'h0;
		adr = 8'h00;
		cb  = 8'h00;
		dat = 32'h0000_0000;
		err_count = 0;
		n_tests = 0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_cap();
		t_read();
		t_buf();
		t_miscmp();
		stop_test();
	end
endmodule
`default_nettype wire
